// ==== hdl/wtc_top.sv ====
// Timeout watchdog: signed down counter, interrupt and reset request
//
// How it works
// - Each time base tick lowers the count by one unless the counter is frozen or written in that cycle.
// - Reset loads the count with 255, about 2.6 s of timeout.
// - In interrupt mode the count runs on below zero through the sign bit: 1, 0, 1ff, 1fe down to 1f1.
// - In interrupt mode reaching zero raises the interrupt and reaching -16 or less the reset.
// - In direct mode the reset fires as soon as the count is zero or below, with no interrupt.
// - The watchdog reset reloads the count to 255 and is a system reset only.
// - A core debug halt freezes the count, and software cannot stop that.
// - Writing one to the freeze set bit in interrupt mode freezes the count.
// - Writing one to the freeze clear bit lets the count run again unless a debug halt still freezes it.
// - The direct mode bit is set by software only and cleared only by system reset.
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module wtc_top
#(
  parameter int TICK_CYCLES = wtc_pkg::TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wtc_pkg::wtc_wb_req_t wb_req,
  output wtc_pkg::wtc_wb_rsp_t wb_rsp,
  input wire logic dbg_halt,
  output logic nmi,
  output logic timeout_unit_rst,
  output logic irq
);

  logic tick;
  logic halted;
  logic [8:0] cnt;
  logic direct;
  logic frz_sw;
  logic [2:0] status;
  logic [2:0] mask;
  logic ack;
  logic [31:0] rdata;

  // Time base and debug halt input
  wtc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  wtc_sync u_halt_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(dbg_halt),
    .sync_out(halted)
  );

  // Bus decode; writes land at the edge where ack is sampled high
  wire bus_req = wb_req.cyc && wb_req.stb;
  wire wr_fire = bus_req && wb_req.we && ack;
  wire lane0 = wb_req.sel[0];
  wire hit_count = (wb_req.adr == wtc_pkg::ADR_COUNT);
  wire hit_ctrl = (wb_req.adr == wtc_pkg::ADR_CTRL);
  wire hit_frz_set = (wb_req.adr == wtc_pkg::ADR_FRZ_SET);
  wire hit_frz_clr = (wb_req.adr == wtc_pkg::ADR_FRZ_CLR);
  wire hit_status = (wb_req.adr == wtc_pkg::ADR_STATUS);
  wire hit_mask = (wb_req.adr == wtc_pkg::ADR_MASK);
  wire [6:0] guard = wb_req.dat[wtc_pkg::GUARD_MSB:wtc_pkg::GUARD_LSB];

  // Count write needs all lanes and a clear guard field
  wire cnt_wr_try = wr_fire && hit_count && (wb_req.sel == wtc_pkg::SEL_ALL);
  wire cnt_wr = cnt_wr_try && (guard == wtc_pkg::GUARD_CLEAR);
  wire ctrl_wr = wr_fire && hit_ctrl && lane0;
  wire frz_set_wr = wr_fire && hit_frz_set && lane0;
  wire frz_clr_wr = wr_fire && hit_frz_clr && lane0;
  wire status_wr = wr_fire && hit_status && lane0;
  wire mask_wr = wr_fire && hit_mask && lane0;

  // Freeze sources: debug halt cannot be masked by software
  wire frozen = halted || frz_sw;

  // Decrement decision and the events it produces
  wire dec = tick && !frozen && !cnt_wr;
  wire [8:0] cnt_dec = cnt - wtc_pkg::CNT_STEP;
  wire dec_zero = (cnt_dec == wtc_pkg::CNT_ZERO);
  wire dec_neg = cnt_dec[wtc_pkg::CNT_SIGN];
  wire dec_floor = dec_neg && (cnt_dec <= wtc_pkg::CNT_FLOOR);
  wire nmi_evt = dec && !direct && dec_zero;
  wire rst_mode = direct ? (dec_zero || dec_neg) : dec_floor;
  wire rst_evt = dec && rst_mode;
  wire neg_evt = dec && dec_neg && !cnt[wtc_pkg::CNT_SIGN];
  wire [2:0] events = {neg_evt, rst_evt, nmi_evt};

  // Next count: watchdog reset reload, then software write, then decrement
  wire [8:0] next_cnt = rst_evt ? wtc_pkg::CNT_RESET :
                        cnt_wr ? wb_req.dat[8:0] :
                        dec ? cnt_dec : cnt;

  // Timeout counter
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt <= wtc_pkg::CNT_RESET;
    end
    else
    begin
      cnt <= next_cnt;
    end
  end

  // Direct mode bit: write one sets it, only reset clears it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      direct <= 1'b0;
    end
    else if (ctrl_wr && wb_req.dat[wtc_pkg::CTRL_DIRECT_BIT])
    begin
      direct <= 1'b1;
    end
  end

  // Software freeze, set only in interrupt mode
  wire frz_set = frz_set_wr && wb_req.dat[wtc_pkg::FRZ_BIT] && !direct;
  wire frz_clr = frz_clr_wr && wb_req.dat[wtc_pkg::FRZ_BIT];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      frz_sw <= 1'b0;
    end
    else if (frz_set)
    begin
      frz_sw <= 1'b1;
    end
    else if (frz_clr)
    begin
      frz_sw <= 1'b0;
    end
  end

  // Sticky status, write one to clear, new event wins
  wire [2:0] st_clr = status_wr ? wb_req.dat[2:0] : wtc_pkg::EVT_NONE;
  wire [2:0] next_status = (status & ~st_clr) | events;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      status <= wtc_pkg::EVT_NONE;
      mask <= wtc_pkg::EVT_NONE;
    end
    else
    begin
      status <= next_status;
      if (mask_wr)
      begin
        mask <= wb_req.dat[2:0];
      end
    end
  end

  // Event outputs: nmi and reset are one-cycle pulses from flip-flops; irq is a combinational level of status and mask
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      nmi <= 1'b0;
      timeout_unit_rst <= 1'b0;
    end
    else
    begin
      nmi <= nmi_evt;
      timeout_unit_rst <= rst_evt;
    end
  end

  assign irq = |(status & mask);

  // Read mux; unmapped offsets read zero
  wire [31:0] rd_count = {23'h000000, cnt};
  wire [31:0] rd_ctrl = {31'h00000000, direct};
  wire [31:0] rd_frz = {30'h00000000, halted, frz_sw};
  wire [31:0] rd_status = {29'h00000000, status};
  wire [31:0] rd_mask = {29'h00000000, mask};
  wire [31:0] next_rdata = hit_count ? rd_count :
                           hit_ctrl ? rd_ctrl :
                           (hit_frz_set || hit_frz_clr) ? rd_frz :
                           hit_status ? rd_status :
                           hit_mask ? rd_mask : wtc_pkg::DATA_ZERO;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      rdata <= wtc_pkg::DATA_ZERO;
    end
    else
    begin
      ack <= bus_req && !ack;
      if (bus_req && !ack)
      begin
        rdata <= next_rdata;
      end
    end
  end

  assign wb_rsp.ack = ack;
  assign wb_rsp.dat = rdata;

  // Checks on the counter and its events
  a_reset_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_evt |=> (cnt == wtc_pkg::CNT_RESET) && timeout_unit_rst)
    else $error("watchdog reset did not reload the count");

  a_tick_step: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && !frozen && !cnt_wr && !rst_evt) |=> (cnt == $past(cnt) - wtc_pkg::CNT_STEP))
    else $error("count did not step down on a tick");

  a_freeze_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (frozen && !cnt_wr) |=> (cnt == $past(cnt)) && !nmi && !timeout_unit_rst)
    else $error("frozen count moved or raised an event");

  a_sign_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    (dec && !direct && cnt == wtc_pkg::CNT_ZERO) |=> (cnt == wtc_pkg::CNT_MINUS1))
    else $error("count did not wrap into the sign bit");

  a_nmi_at_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (dec && !direct && cnt == wtc_pkg::CNT_ONE) |=>
      nmi && !timeout_unit_rst && (cnt == wtc_pkg::CNT_ZERO))
    else $error("interrupt missing at zero");

  a_rst_floor: assert property (@(posedge mclk) disable iff (!rst_n)
    (dec && !direct && cnt == (wtc_pkg::CNT_FLOOR + wtc_pkg::CNT_STEP)) |=>
      timeout_unit_rst && !nmi)
    else $error("reset missing at minus sixteen");

  a_rst_direct: assert property (@(posedge mclk) disable iff (!rst_n)
    (dec && direct && cnt == wtc_pkg::CNT_ONE) |=> timeout_unit_rst ##1 !timeout_unit_rst)
    else $error("direct mode reset missing at zero");

  a_direct_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    direct |=> direct)
    else $error("direct mode bit cleared without reset");

  a_guard_block: assert property (@(posedge mclk) disable iff (!rst_n)
    (cnt_wr_try && guard != wtc_pkg::GUARD_CLEAR && !tick) |=> (cnt == $past(cnt)))
    else $error("guarded count write was taken");

  a_freeze_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (frz_set_wr && wb_req.dat[wtc_pkg::FRZ_BIT] && !direct) |=> frz_sw [*2])
    else $error("software freeze not taken");

  a_freeze_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (frz_clr_wr && wb_req.dat[wtc_pkg::FRZ_BIT] && !frz_set) |=> !frz_sw)
    else $error("software freeze not released");

  a_freeze_direct: assert property (@(posedge mclk) disable iff (!rst_n)
    (frz_set_wr && direct && !frz_sw) |=> !frz_sw)
    else $error("freeze taken in direct mode");

  a_count_write: assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_wr |=> (cnt == $past(wb_req.dat[8:0])))
    else $error("clean count write not taken");

  a_direct_no_nmi: assert property (@(posedge mclk) disable iff (!rst_n)
    direct |=> !nmi)
    else $error("interrupt raised in direct mode");

  a_direct_neg_rst: assert property (@(posedge mclk) disable iff (!rst_n)
    (dec && direct && dec_neg) |=> timeout_unit_rst && (cnt == wtc_pkg::CNT_RESET))
    else $error("direct mode reset missing below zero");

  a_rst_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    timeout_unit_rst |=> !timeout_unit_rst)
    else $error("watchdog reset longer than one cycle");

  // Checks on the status flags and the bus answer
  a_status_nmi: assert property (@(posedge mclk) disable iff (!rst_n)
    nmi_evt |=> status[wtc_pkg::EVT_NMI])
    else $error("interrupt event not recorded");

  a_status_neg: assert property (@(posedge mclk) disable iff (!rst_n)
    neg_evt |=> status[wtc_pkg::EVT_NEG])
    else $error("negative count event not recorded");

  a_ack_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_req && !ack) |=> ack)
    else $error("bus request not answered");

  a_ack_single: assert property (@(posedge mclk) disable iff (!rst_n)
    ack |=> !ack)
    else $error("ack held longer than one cycle");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_req && !ack && !hit_count && !hit_ctrl && !hit_frz_set && !hit_frz_clr &&
      !hit_status && !hit_mask) |=> (wb_rsp.dat == wtc_pkg::DATA_ZERO))
    else $error("unmapped read returned data");

endmodule

// ==== inc/wtc_pkg.sv ====
// Constants, register map and bus carrier types of the timeout watchdog
package wtc_pkg;

  // Time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_US = 10240;
  localparam int TICK_CYCLES = (TICK_TIME_US * 1000) / CLK_PERIOD_NS; // 2560000 clocks

  // Counter layout
  localparam int CNT_W = 9;
  localparam logic [8:0] CNT_RESET = 9'h0ff;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [8:0] CNT_STEP = 9'h001;
  localparam logic [8:0] CNT_MINUS1 = 9'h1ff;
  localparam logic [8:0] CNT_FLOOR = 9'h1f0;
  localparam int CNT_SIGN = 8;
  localparam int GUARD_LSB = 9;
  localparam int GUARD_MSB = 15;
  localparam logic [6:0] GUARD_CLEAR = 7'h00;

  // Register offsets (byte addresses)
  localparam logic [7:0] ADR_COUNT = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_FRZ_SET = 8'h08;
  localparam logic [7:0] ADR_FRZ_CLR = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_MASK = 8'h14;

  // Field positions
  localparam int CTRL_DIRECT_BIT = 0;
  localparam int FRZ_BIT = 0;
  localparam int FRZ_HALT_BIT = 1;
  localparam int EVT_W = 3;
  localparam int EVT_NMI = 0;
  localparam int EVT_RST = 1;
  localparam int EVT_NEG = 2;
  localparam logic [2:0] EVT_NONE = 3'h0;
  localparam logic [3:0] SEL_ALL = 4'hf;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // Classic Wishbone request from the bus master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wtc_wb_req_t;

  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wtc_wb_rsp_t;

endpackage

// ==== hdl/wtc_sync.sv ====
// Three-stage synchroniser with agreement filter for an outside level
`timescale 1ns/10ps
module wtc_sync
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Shift chain; output follows only when stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
      begin
        sync_out <= stage3;
      end
    end
  end

endmodule

// ==== hdl/wtc_tick.sv ====
// Free-running divider producing the watchdog time base strobe
`timescale 1ns/10ps
module wtc_tick
#(
  parameter int TICK_CYCLES = wtc_pkg::TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick
);

  localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

  logic [31:0] count;
  logic at_last;

  assign at_last = (count == LAST);

  // Count cycles and pulse once per period
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else
    begin
      count <= at_last ? 32'h0000_0000 : count + 32'h0000_0001;
      tick <= at_last;
    end
  end

endmodule

// ==== sim/wtc_top_bench.sv ====
// Self-checking bench of the timeout watchdog driven over its register bus
`timescale 1ns/10ps
module wtc_top_bench;
  localparam int TICKS = 8;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic dbg_halt = 1'b0;
  wtc_pkg::wtc_wb_req_t wb_req = '0;
  wtc_pkg::wtc_wb_rsp_t wb_rsp;
  logic nmi;
  logic timeout_unit_rst;
  logic irq;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_nmi = 0;
  int n_rst = 0;
  int cyc_n;
  int base;
  int m;
  logic [31:0] rd;

  // Clock of 4 ns
  always #2 mclk = ~mclk;

  wtc_top #(.TICK_CYCLES(TICKS)) u_wtc_top (
    .mclk(mclk),
    .rst_n(rst_n),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .dbg_halt(dbg_halt),
    .nmi(nmi),
    .timeout_unit_rst(timeout_unit_rst),
    .irq(irq)
  );

  // Counts interrupt and reset pulses
  always @(posedge mclk)
  begin
    if (nmi === 1'b1)
      n_nmi <= n_nmi + 1;
    if (timeout_unit_rst === 1'b1)
      n_rst <= n_rst + 1;
  end

  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; data taken at the ack edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
    input logic [31:0] dat);
    int k;
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    for (k = 0; k < 20; k++)
    begin
      @(posedge mclk);
      if (wb_rsp.ack === 1'b1)
        break;
    end
    rd = wb_rsp.dat;
    wb_req <= '0;
    if (k == 20)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, wtc_pkg::SEL_ALL, dat);
  endtask

  task automatic rd_reg(input logic [7:0] adr);
    wb_xfer(1'b0, adr, wtc_pkg::SEL_ALL, wtc_pkg::DATA_ZERO);
  endtask

  // Waits for a pulse of nmi or timeout_unit_rst, bounded
  task automatic wait_pulse(input bit rst_sel, input int bound, output int cycles);
    cycles = 0;
    while (cycles < bound)
    begin
      @(posedge mclk);
      cycles++;
      if ((rst_sel ? timeout_unit_rst : nmi) === 1'b1)
        return;
    end
    n_mismatch++;
    give_verdict();
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(wtc_pkg::ADR_COUNT);
    check("count reset", rd, {23'h000000, wtc_pkg::CNT_RESET});
    rd_reg(wtc_pkg::ADR_CTRL);
    check("ctrl reset", rd, 32'h0000_0000);
    rd_reg(8'h20);
    check("unmapped read", rd, 32'h0000_0000);
    // Guarded writes checked on a frozen count so ticks cannot move it
    wr(wtc_pkg::ADR_FRZ_SET, 32'h0000_0001);
    wr(wtc_pkg::ADR_COUNT, 32'h0000_0040);
    wr(wtc_pkg::ADR_COUNT, 32'h0000_fe05);
    wb_xfer(1'b1, wtc_pkg::ADR_COUNT, 4'h1, 32'h0000_0005);
    rd_reg(wtc_pkg::ADR_COUNT);
    check("guarded write", rd, 32'h0000_0040);
    wr(wtc_pkg::ADR_FRZ_CLR, 32'h0000_0001);
    wr(wtc_pkg::ADR_COUNT, 32'h0000_0003);
    wait_pulse(1'b0, 40, cyc_n);
    wait_pulse(1'b1, 200, cyc_n);
    check("nmi to reset", 32'(cyc_n), 32'(16 * TICKS));
    rd_reg(wtc_pkg::ADR_COUNT);
    check("count reload", rd, 32'h0000_00ff);
    rd_reg(wtc_pkg::ADR_STATUS);
    check("status events", rd, 32'h0000_0007);
    wr(wtc_pkg::ADR_MASK, 32'h0000_0001);
    @(posedge mclk);
    check("irq masked on", {31'h0, irq}, 32'h0000_0001);
    wr(wtc_pkg::ADR_STATUS, 32'h0000_0001);
    @(posedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rd_reg(wtc_pkg::ADR_STATUS);
    check("status clear", rd, 32'h0000_0006);
    // Handler reload after the interrupt keeps the reset away
    wr(wtc_pkg::ADR_COUNT, 32'h0000_0001);
    wait_pulse(1'b0, 40, cyc_n);
    wr(wtc_pkg::ADR_COUNT, 32'h0000_0080);
    base = n_rst;
    repeat (17 * TICKS) @(posedge mclk);
    check("reset prevented", 32'(n_rst - base), 32'h0000_0000);
    // Software freeze, then debug halt freeze
    for (m = 0; m < 2; m++)
    begin
      if (m == 0)
        wr(wtc_pkg::ADR_FRZ_SET, 32'h0000_0001);
      else
      begin
        dbg_halt <= 1'b1;
        repeat (8) @(posedge mclk);
      end
      rd_reg(wtc_pkg::ADR_FRZ_SET);
      check("freeze state", rd, (m == 0) ? 32'h0000_0001 : 32'h0000_0002);
      base = n_nmi;
      wr(wtc_pkg::ADR_COUNT, 32'h0000_0001);
      repeat (5 * TICKS) @(posedge mclk);
      rd_reg(wtc_pkg::ADR_COUNT);
      check("frozen count", rd, 32'h0000_0001);
      check("nmi while frozen", 32'(n_nmi - base), 32'h0000_0000);
      if (m == 0)
        wr(wtc_pkg::ADR_FRZ_CLR, 32'h0000_0001);
      else
        dbg_halt <= 1'b0;
      wait_pulse(1'b0, 40, cyc_n);
    end
    // Direct reset mode
    wr(wtc_pkg::ADR_CTRL, 32'h0000_0001);
    wr(wtc_pkg::ADR_CTRL, 32'h0000_0000);
    rd_reg(wtc_pkg::ADR_CTRL);
    check("direct sticky", rd, 32'h0000_0001);
    wr(wtc_pkg::ADR_FRZ_SET, 32'h0000_0001);
    rd_reg(wtc_pkg::ADR_FRZ_SET);
    check("freeze in direct", rd, 32'h0000_0000);
    wr(wtc_pkg::ADR_COUNT, 32'h0000_0002);
    base = n_nmi;
    wait_pulse(1'b1, 40, cyc_n);
    check("no nmi direct", 32'(n_nmi - base), 32'h0000_0000);
    rd_reg(wtc_pkg::ADR_COUNT);
    check("direct reload", rd, 32'h0000_00ff);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(wtc_pkg::ADR_CTRL);
    check("direct cleared", rd, 32'h0000_0000);
    give_verdict();
  end
endmodule
